// ===== design/profile_setup_pkg.sv
package profile_setup_pkg;

  // frame layout shared by every setup message
  localparam int          NUM_CHANNELS      = 8;
  localparam int          FRAME_WIDTH       = 32;
  localparam int          RW_BIT            = 31;
  localparam int          ID_MSB            = 30;
  localparam int          ID_LSB            = 27;
  localparam int          CHANNEL_SELECT_FIELD_MSB          = 26;
  localparam int          CHANNEL_SELECT_FIELD_LSB          = 24;
  localparam logic [3:0]  ID_SETUP1         = 4'h9;  // 1001
  localparam logic [3:0]  ID_SETUP2         = 4'hA;  // 1010

  // first setup frame fields
  localparam int          THR3_LSB          = 20;
  localparam int          THR2_LSB          = 16;
  localparam int          THR1_LSB          = 12;
  localparam int          CNT3_LSB          = 8;
  localparam int          CNT2_LSB          = 4;
  localparam int          CNT1_LSB          = 0;
  localparam int          ZONE_FIELD_WIDTH  = 4;

  // second setup frame fields
  localparam int          TIMEOUT_LSB       = 4;
  localparam int          TIMEOUT_WIDTH     = 6;
  localparam int          ZONE3_SEL_LSB     = 0;
  localparam int          ZONE3_SEL_WIDTH   = 2;

  // reset values
  localparam logic [3:0]  ZONE_FIELD_RESET  = 4'h0;
  localparam logic [5:0]  TIMEOUT_RESET     = 6'h00;
  localparam logic [1:0]  ZONE3_SEL_RESET   = 2'h0;

  // one timeout step is this many converter sample periods
  localparam int          SAMPLES_PER_STEP  = 16;
  localparam int          TIMEOUT_SAMPLES_W = 10;

  typedef struct packed {
    logic [3:0] thr3;
    logic [3:0] thr2;
    logic [3:0] thr1;
    logic [3:0] cnt3;
    logic [3:0] cnt2;
    logic [3:0] cnt1;
  } zone_setup_type;

  typedef struct packed {
    logic [5:0] timeout;
    logic [1:0] zone3_sel;
  } timeout_setup_type;

  typedef struct packed {
    logic       rw;
    logic [3:0] message_identifier_field;
    logic [2:0] channel_select_field;
    logic [23:0] payload;
  } frame_fields_type;

  // timeout steps to sample periods
  function automatic logic [TIMEOUT_SAMPLES_W-1:0] timeout_to_samples(input logic [5:0] t);
    timeout_to_samples = TIMEOUT_SAMPLES_W'(t) * TIMEOUT_SAMPLES_W'(SAMPLES_PER_STEP);
  endfunction : timeout_to_samples

  // zone 3 selector to sample lag, 1..4
  function automatic logic [2:0] select_to_lag(input logic [1:0] sel);
    select_to_lag = {1'b0, sel} + 3'h1;
  endfunction : select_to_lag

endpackage : profile_setup_pkg

// ===== design/setup_frame_decode.sv
`timescale 1ns/1ps
module setup_frame_decode
  import profile_setup_pkg::*;
(
  input  wire logic [FRAME_WIDTH-1:0] frame,
  output frame_fields_type            fields,
  output logic                        is_setup1,
  output logic                        is_setup2
);

  // split the frame and recognise the two setup identifiers
  always_comb begin
    fields.rw                       = frame[RW_BIT];
    fields.message_identifier_field = frame[ID_MSB:ID_LSB];
    fields.channel_select_field     = frame[CHANNEL_SELECT_FIELD_MSB:CHANNEL_SELECT_FIELD_LSB];
    fields.payload                  = frame[23:0];
    is_setup1 = (frame[ID_MSB:ID_LSB] == ID_SETUP1);
    is_setup2 = (frame[ID_MSB:ID_LSB] == ID_SETUP2);
  end

endmodule : setup_frame_decode

// ===== design/current_profile_setup_regs.sv
`timescale 1ns/1ps
module current_profile_setup_regs
  import profile_setup_pkg::*;
#(
  parameter int N_CH = NUM_CHANNELS
) (
  input  wire logic                                     clk,
  input  wire logic                                     srst,
  input  wire logic                                     ce,
  input  wire logic                                     frame_valid,
  input  wire logic [FRAME_WIDTH-1:0]                   frame_data,
  output logic                                          resp_valid,
  output logic [FRAME_WIDTH-1:0]                        resp_data,
  output zone_setup_type    [N_CH-1:0]                  zone_cfg,
  output timeout_setup_type [N_CH-1:0]                  timeout_cfg,
  output logic [N_CH-1:0][TIMEOUT_SAMPLES_W-1:0]        timeout_samples,
  output logic [N_CH-1:0][2:0]                          sample_difference
);

  frame_fields_type                 fields;
  logic                             is_setup1;
  logic                             is_setup2;
  logic                             take1;
  logic                             take2;
  zone_setup_type    [N_CH-1:0]     zone_q;
  timeout_setup_type [N_CH-1:0]     tmo_q;
  zone_setup_type                   zone_sel;
  timeout_setup_type                tmo_sel;
  zone_setup_type                   zone_new;
  timeout_setup_type                tmo_new;
  logic                             resp_valid_q;
  logic [FRAME_WIDTH-1:0]           resp_data_q;
  logic [FRAME_WIDTH-1:0]           resp_data_d;
  logic [N_CH-1:0][TIMEOUT_SAMPLES_W-1:0] samples_q;
  logic [N_CH-1:0][2:0]             lag_q;

  setup_frame_decode u_decode (
    .frame     (frame_data),
    .fields    (fields),
    .is_setup1 (is_setup1),
    .is_setup2 (is_setup2)
  );

  // frames accepted only while enabled
  assign take1 = ce && frame_valid && is_setup1;
  assign take2 = ce && frame_valid && is_setup2;

  // current contents of the addressed channel and the written image
  always_comb begin
    zone_sel = zone_q[fields.channel_select_field];
    tmo_sel  = tmo_q[fields.channel_select_field];
    zone_new.thr3 = fields.payload[THR3_LSB +: ZONE_FIELD_WIDTH];
    zone_new.thr2 = fields.payload[THR2_LSB +: ZONE_FIELD_WIDTH];
    zone_new.thr1 = fields.payload[THR1_LSB +: ZONE_FIELD_WIDTH];
    zone_new.cnt3 = fields.payload[CNT3_LSB +: ZONE_FIELD_WIDTH];
    zone_new.cnt2 = fields.payload[CNT2_LSB +: ZONE_FIELD_WIDTH];
    zone_new.cnt1 = fields.payload[CNT1_LSB +: ZONE_FIELD_WIDTH];
    tmo_new.timeout   = fields.payload[TIMEOUT_LSB +: TIMEOUT_WIDTH];
    tmo_new.zone3_sel = fields.payload[ZONE3_SEL_LSB +: ZONE3_SEL_WIDTH];
    if (fields.rw) begin
      zone_sel = zone_new;
      tmo_sel  = tmo_new;
    end
  end

  // zone thresholds and counts per channel
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < N_CH; i++) begin
        zone_q[i] <= {6{ZONE_FIELD_RESET}};
      end
    end else if (take1 && fields.rw) begin
      zone_q[fields.channel_select_field] <= zone_new;
    end
  end

  // timeout and zone 3 selector per channel
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < N_CH; i++) begin
        tmo_q[i] <= {TIMEOUT_RESET, ZONE3_SEL_RESET};
      end
    end else if (take2 && fields.rw) begin
      tmo_q[fields.channel_select_field] <= tmo_new;
    end
  end

  // answer image: bit 31 low, identifier and channel echoed, unused zero
  always_comb begin
    resp_data_d = 32'h0000_0000;
    resp_data_d[ID_MSB:ID_LSB]     = fields.message_identifier_field;
    resp_data_d[CHANNEL_SELECT_FIELD_MSB:CHANNEL_SELECT_FIELD_LSB] = fields.channel_select_field;
    if (is_setup1) begin
      resp_data_d[23:0] = zone_sel;
    end else begin
      resp_data_d[TIMEOUT_LSB +: TIMEOUT_WIDTH]     = tmo_sel.timeout;
      resp_data_d[ZONE3_SEL_LSB +: ZONE3_SEL_WIDTH] = tmo_sel.zone3_sel;
    end
  end

  // answer strobe, one enabled cycle per accepted frame
  always_ff @(posedge clk) begin
    if (srst) begin
      resp_valid_q <= 1'b0;
    end else if (ce) begin
      resp_valid_q <= take1 || take2;
    end
  end

  // answer word held until the next accepted frame
  always_ff @(posedge clk) begin
    if (srst) begin
      resp_data_q <= 32'h0000_0000;
    end else if (take1 || take2) begin
      resp_data_q <= resp_data_d;
    end
  end

  // settings toward the detection logic, loaded in step with the stored timeout
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < N_CH; i++) begin
        samples_q[i] <= timeout_to_samples(TIMEOUT_RESET);
        lag_q[i]     <= select_to_lag(ZONE3_SEL_RESET);
      end
    end else if (take2 && fields.rw) begin
      samples_q[fields.channel_select_field] <= timeout_to_samples(tmo_new.timeout);
      lag_q[fields.channel_select_field]     <= select_to_lag(tmo_new.zone3_sel);
    end
  end

  assign zone_cfg          = zone_q;
  assign timeout_cfg       = tmo_q;
  assign timeout_samples   = samples_q;
  assign sample_difference = lag_q;
  assign resp_valid        = resp_valid_q;
  assign resp_data         = resp_data_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence wr1_s;
    ce && frame_valid && is_setup1 && frame_data[RW_BIT];
  endsequence

  sequence wr2_s;
    ce && frame_valid && is_setup2 && frame_data[RW_BIT];
  endsequence

  sequence rd_any_s;
    ce && frame_valid && (is_setup1 || is_setup2) && !frame_data[RW_BIT];
  endsequence

  sequence rd1_s;
    ce && frame_valid && is_setup1 && !frame_data[RW_BIT];
  endsequence

  sequence rd2_s;
    ce && frame_valid && is_setup2 && !frame_data[RW_BIT];
  endsequence

  setup1_answer_a: assert property (
    ce && frame_valid && is_setup1 |=> resp_valid
      && resp_data[ID_MSB:ID_LSB] == ID_SETUP1
      && resp_data[CHANNEL_SELECT_FIELD_MSB:CHANNEL_SELECT_FIELD_LSB] == $past(frame_data[CHANNEL_SELECT_FIELD_MSB:CHANNEL_SELECT_FIELD_LSB]))
    else $error("setup one frame not answered");

  setup2_answer_a: assert property (
    ce && frame_valid && is_setup2 |=> resp_valid
      && resp_data[ID_MSB:ID_LSB] == ID_SETUP2)
    else $error("setup two frame not answered");

  foreign_ignored_a: assert property (
    ce && !(frame_valid && (is_setup1 || is_setup2)) |=> !resp_valid)
    else $error("answer without setup frame");

  zone_write_a: assert property (
    wr1_s |=> zone_q[$past(frame_data[CHANNEL_SELECT_FIELD_MSB:CHANNEL_SELECT_FIELD_LSB])] == $past(frame_data[23:0])
      && resp_data[23:0] == $past(frame_data[23:0]))
    else $error("zone write not stored");

  read_keeps_a: assert property (
    rd_any_s |=> $stable(zone_q) && $stable(tmo_q))
    else $error("read changed settings");

  zone_reset_a: assert property (@(posedge clk) disable iff (1'b0)
    srst |=> zone_q == '0)
    else $error("zone settings not cleared");

  timeout_reset_a: assert property (@(posedge clk) disable iff (1'b0)
    srst |=> timeout_samples == '0 && tmo_q == '0)
    else $error("timeout not cleared");

  timeout_scale_a: assert property (
    wr2_s |=> timeout_samples[$past(frame_data[CHANNEL_SELECT_FIELD_MSB:CHANNEL_SELECT_FIELD_LSB])]
      == TIMEOUT_SAMPLES_W'($past(frame_data[9:4])) * TIMEOUT_SAMPLES_W'(SAMPLES_PER_STEP))
    else $error("timeout scaling wrong");

  lag_select_a: assert property (
    wr2_s |=> sample_difference[$past(frame_data[CHANNEL_SELECT_FIELD_MSB:CHANNEL_SELECT_FIELD_LSB])]
      == 3'($past(frame_data[1:0])) + 3'h1)
    else $error("sample lag wrong");

  answer_format_a: assert property (
    resp_valid |-> !resp_data[RW_BIT]
      && (resp_data[ID_MSB:ID_LSB] == ID_SETUP1
          || (resp_data[23:10] == 14'h0000 && resp_data[3:2] == 2'h0)))
    else $error("answer format wrong");

  timeout_write_a: assert property (
    wr2_s |=> tmo_q[$past(frame_data[CHANNEL_SELECT_FIELD_MSB:CHANNEL_SELECT_FIELD_LSB])].timeout
      == $past(frame_data[TIMEOUT_LSB +: TIMEOUT_WIDTH])
      && resp_data[TIMEOUT_LSB +: TIMEOUT_WIDTH]
      == $past(frame_data[TIMEOUT_LSB +: TIMEOUT_WIDTH]))
    else $error("timeout write not stored");

  zone_read_a: assert property (
    rd1_s |=> resp_data[23:0] == $past(zone_q[frame_data[CHANNEL_SELECT_FIELD_MSB:CHANNEL_SELECT_FIELD_LSB]]))
    else $error("zone read answer wrong");

  timeout_read_a: assert property (
    rd2_s |=> resp_data[TIMEOUT_LSB +: TIMEOUT_WIDTH]
      == $past(tmo_q[frame_data[CHANNEL_SELECT_FIELD_MSB:CHANNEL_SELECT_FIELD_LSB]].timeout))
    else $error("timeout read answer wrong");

  enable_freeze_a: assert property (
    !ce |=> $stable(zone_q) && $stable(tmo_q) && $stable(resp_valid))
    else $error("state moved while disabled");

  answer_hold_a: assert property (
    !(ce && frame_valid && (is_setup1 || is_setup2)) |=> $stable(resp_data))
    else $error("answer word changed without frame");

endmodule : current_profile_setup_regs

// ===== verification/host_model.sv
`timescale 1ns/1ps
module host_model
  import profile_setup_pkg::*;
(
  input  wire logic                   clk,
  output logic                        frame_valid,
  output logic [FRAME_WIDTH-1:0]      frame_data,
  input  wire logic                   resp_valid,
  input  wire logic [FRAME_WIDTH-1:0] resp_data
);
  // idle before the first frame
  initial begin
    frame_valid = 1'b0;
    frame_data  = 32'h0000_0000;
  end

  // one frame, answer sampled 1 ns after the edge that takes it
  task automatic xfer(input logic [FRAME_WIDTH-1:0] f, output logic [FRAME_WIDTH-1:0] r,
                      output logic got);
    @(posedge clk);
    frame_valid <= 1'b1;
    frame_data  <= f;
    @(posedge clk);
    frame_valid <= 1'b0;
    frame_data  <= ~f;  // released word does not keep its value
    #1;
    got = resp_valid;
    r   = resp_data;
  endtask : xfer
endmodule : host_model

// ===== verification/current_profile_setup_regs_test.sv
`timescale 1ns/1ps
module current_profile_setup_regs_test;
  import profile_setup_pkg::*;
  logic                                           clk, srst, ce, frame_valid, resp_valid, got;
  logic              [FRAME_WIDTH-1:0]            frame_data, resp_data, r;
  zone_setup_type    [NUM_CHANNELS-1:0]           zone_cfg;
  timeout_setup_type [NUM_CHANNELS-1:0]           timeout_cfg;
  logic [NUM_CHANNELS-1:0][TIMEOUT_SAMPLES_W-1:0] timeout_samples;
  logic [NUM_CHANNELS-1:0][2:0]                   sample_difference;
  logic              [23:0]                       z;
  logic              [5:0]                        t;
  int                                             mismatches, n_tests;

  current_profile_setup_regs #(.N_CH(NUM_CHANNELS)) i_dut (
    .clk(clk), .srst(srst), .ce(ce), .frame_valid(frame_valid), .frame_data(frame_data),
    .resp_valid(resp_valid), .resp_data(resp_data), .zone_cfg(zone_cfg),
    .timeout_cfg(timeout_cfg), .timeout_samples(timeout_samples),
    .sample_difference(sample_difference));
  host_model i_host (.clk(clk), .frame_valid(frame_valid), .frame_data(frame_data),
    .resp_valid(resp_valid), .resp_data(resp_data));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // one frame that must be answered with the given word
  task automatic xchk(input string name, input logic [31:0] f, input logic [31:0] exp);
    i_host.xfer(f, r, got);
    check({name, " answered"}, 32'(got), 32'h0000_0001);
    check(name, r, exp);
  endtask : xchk

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  // hang guard, tests need about 90 cycles
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    results();
  end

  initial begin
    srst = 1'b1;
    ce = 1'b1;
    mismatches = 0;
    n_tests = 0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    // reset values of every channel, setup two read with junk in the data bits
    for (int c = 0; c < 8; c++) begin
      xchk("s1 rst", {1'b0, ID_SETUP1, 3'(c), 24'h00_0000},
           {1'b0, ID_SETUP1, 3'(c), 24'h00_0000});
      xchk("s2 rst", {1'b0, ID_SETUP2, 3'(c), 24'hFF_FFFF},
           {1'b0, ID_SETUP2, 3'(c), 24'h00_0000});
      check("lag rst", 32'(sample_difference[c]), 32'h0000_0001);
    end
    $display("test reset done");
    // zone fields: write every channel, then read all back
    for (int w = 1; w >= 0; w--) begin
      for (int c = 0; c < 8; c++) begin
        z = 24'h12_3456 + 24'h11_1111 * 24'(c);
        xchk("s1", {1'(w), ID_SETUP1, 3'(c), z},
             {1'b0, ID_SETUP1, 3'(c), z});
        check("thr3", 32'(zone_cfg[c].thr3), 32'(z[23:20]));
        check("cnt1", 32'(zone_cfg[c].cnt1), 32'(z[3:0]));
        check("zone cfg", 32'(zone_cfg[c]), 32'(z));
      end
    end
    $display("test zone done");
    // timeout and every lag code, unused bits set on write
    for (int w = 1; w >= 0; w--) begin
      for (int s = 0; s < 4; s++) begin
        t = 6'h3F - 6'(s * 21);
        xchk("s2", {1'(w), ID_SETUP2, 3'(s + 4), 14'h3FFF & {14{w[0]}}, t, 2'h3, 2'(s)},
             {1'b0, ID_SETUP2, 3'(s + 4), 14'h0000, t, 2'h0, 2'(s)});
        check("samples", 32'(timeout_samples[s + 4]), 32'({t, 4'h0}));
        check("lag", 32'(sample_difference[s + 4]), 32'(s + 1));
        check("tmo cfg", 32'(timeout_cfg[s + 4]), 32'({t, 2'(s)}));
      end
    end
    $display("test timeout done");
    // foreign identifier and frame while disabled are ignored
    i_host.xfer({1'b1, 4'hB, 3'h0, 24'h00_0000}, r, got);
    check("foreign id", 32'(got), 32'h0000_0000);
    @(posedge clk);
    ce <= 1'b0;
    i_host.xfer({1'b1, ID_SETUP1, 3'h0, 24'h00_0000}, r, got);
    check("ce low", 32'(got), 32'h0000_0000);
    check("ce hold", 32'(zone_cfg[0]), 32'h0012_3456);
    @(posedge clk);
    ce <= 1'b1;
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1;
    check("zone rst2", 32'(zone_cfg[7]), 32'h0000_0000);
    check("tmo rst2", 32'(timeout_cfg[7]), 32'h0000_0000);
    check("samples rst2", 32'(timeout_samples[4]), 32'h0000_0000);
    check("lag rst2", 32'(sample_difference[7]), 32'h0000_0001);
    $display("test refuse done");
    results();
  end
endmodule : current_profile_setup_regs_test
